// file: rtl/tlic_params.svh
// Register map, field positions, vectors and timing counts of the interrupt controller
//----------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------
// Summary of operation
// (R1) Priority mode: high requests vector to 0008h, low requests to 0018h.
// (R2) An enabled high request may preempt a running low service routine.
// (R3) Each source has an event flag, an enable and a priority selector.
// (R4) Priority mode enable resets cleared, so compatibility mode is the default.
// (R5) Compatibility mode ignores every per-source priority selector.
// (R6) Compatibility: peripheral sources need peripheral enable and global enable both set.
// (R7) Compatibility: global enable permits non-peripheral sources; clear blocks every source.
// (R8) Compatibility mode sends every accepted request to 0008h.
// (R9) Priority mode turns the two global bits into high and low enables.
// (R10) Priority mode: high enable permits high sources; clear blocks all sources.
// (R11) Priority mode: low sources need both high and low enables set.
// (R12) Entry clears the governing global enable: high for high, low for low.
// (R13) No low request is taken while a high service routine runs.
// (R14) Entry pushes the return address and loads the program counter with the vector.
// (R15) Flags stay set until software clears them, so they re-trigger later.
// (R16) Return from interrupt leaves the routine and sets the enable entry cleared.
// (R17) Pin events reach the vector three to four instruction cycles later.
// (R18) Flags set on their event regardless of enables.
// (R19) Software must not rewrite control registers by memory-to-memory move while enabled.
// (R20) A level is pending when a source has flag, enable and matching priority.
`ifndef TLIC_PARAMS_SVH
`define TLIC_PARAMS_SVH
//----------------------------------------------------------------
// Register offsets (byte addresses)
//----------------------------------------------------------------
`define TLIC_OFS_CTRL 8'h00
`define TLIC_OFS_FLAG 8'h04
`define TLIC_OFS_ENABLE 8'h08
`define TLIC_OFS_PRIO 8'h0c
`define TLIC_OFS_STATUS 8'h10
//----------------------------------------------------------------
// Control fields
//----------------------------------------------------------------
`define TLIC_BIT_GHE 7
`define TLIC_BIT_PLE 6
`define TLIC_BIT_PME 5
`define TLIC_CTRL_RST 3'h0
//----------------------------------------------------------------
// Vectors and timing
//----------------------------------------------------------------
`define TLIC_VEC_HIGH 16'h0008
`define TLIC_VEC_LOW 16'h0018
`define TLIC_ENTRY_ICYC 2'h2
`endif

// file: rtl/tlic_pkg.sv
// Types shared by the interrupt controller
package tlic_pkg;
	typedef enum logic [1:0] {
		TLIC_IDLE = 2'b01,
		TLIC_WAIT = 2'b10
	} tlic_state_t;
endpackage : tlic_pkg

// file: rtl/tlic_ctrl.sv
// Two-level interrupt controller with APB register access
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "tlic_params.svh"
module tlic_ctrl #(
	parameter int NSRC = 8,
	parameter logic [NSRC-1:0] PERIPH_MASK = 8'hf0
) (
	input wire logic sys_clk, // Core clock, 25 MHz
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [NSRC-1:0] src_event, // Source event lines from pins
	input wire logic instr_cycle, // One pulse per instruction cycle
	input wire logic return_from_interrupt_instr, // Return executed
	output logic stack_push, // Push return address
	output logic pc_load, // Load program counter
	output logic [15:0] pc_vector, // Vector address
	output logic svc_high, // High routine in progress
	output logic svc_low // Low routine in progress
);
	import tlic_pkg::*;

	//----------------------------------------------------------------
	// State
	//----------------------------------------------------------------
	logic global_high_enable;
	logic peripheral_low_enable;
	logic priority_mode_enable;
	logic [NSRC-1:0] source_flag_regs;
	logic [NSRC-1:0] source_enable_regs;
	logic [NSRC-1:0] source_priority_regs;
	logic [NSRC-1:0] ev_s1, ev_s2, ev_s3;
	logic [NSRC-1:0] ev_rise;
	tlic_state_t st;
	logic [1:0] icnt;
	logic ent_high;
	logic hi_pend, lo_pend, accept, entry;
	logic wr_acc;
	logic [NSRC-1:0] flag_clr;

	function automatic logic any_set(input logic [NSRC-1:0] v);
		any_set = |v;
	endfunction : any_set

	//----------------------------------------------------------------
	// Event capture
	//----------------------------------------------------------------
	// Pins are asynchronous; the third stage only feeds the edge detector
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ev_s1 <= '0;
			ev_s2 <= '0;
			ev_s3 <= '0;
		end else begin
			ev_s1 <= src_event;
			ev_s2 <= ev_s1;
			ev_s3 <= ev_s2;
		end
	end

	assign ev_rise = ev_s2 & ~ev_s3;

	//----------------------------------------------------------------
	// APB access
	//----------------------------------------------------------------
	assign wr_acc = psel && penable && pwrite && pready;
	assign flag_clr = (wr_acc && paddr == `TLIC_OFS_FLAG) ? pwdata[NSRC-1:0] : '0;

	// One wait state per access; pready is a flop
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			prdata <= 32'h0;
			pslverr <= 1'b0;
			if (paddr == `TLIC_OFS_CTRL) begin
				prdata[`TLIC_BIT_GHE] <= global_high_enable;
				prdata[`TLIC_BIT_PLE] <= peripheral_low_enable;
				prdata[`TLIC_BIT_PME] <= priority_mode_enable;
			end else if (paddr == `TLIC_OFS_FLAG) begin
				prdata[NSRC-1:0] <= source_flag_regs;
			end else if (paddr == `TLIC_OFS_ENABLE) begin
				prdata[NSRC-1:0] <= source_enable_regs;
			end else if (paddr == `TLIC_OFS_PRIO) begin
				prdata[NSRC-1:0] <= source_priority_regs;
			end else if (paddr == `TLIC_OFS_STATUS) begin
				prdata[2:0] <= {st == TLIC_WAIT, svc_high, svc_low};
			end else begin
				pslverr <= 1'b1;
			end
		end else begin
			pslverr <= 1'b0;
		end
	end

	//----------------------------------------------------------------
	// Source registers
	//----------------------------------------------------------------
	// A new event beats a software clear in the same cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			source_flag_regs <= '0;
		end else begin
			source_flag_regs <= (source_flag_regs & ~flag_clr) | ev_rise; // see (R15) see (R18)
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			source_enable_regs <= '0;
			source_priority_regs <= '0;
		end else if (wr_acc) begin
			if (paddr == `TLIC_OFS_ENABLE) begin
				source_enable_regs <= pwdata[NSRC-1:0]; // see (R3)
			end else if (paddr == `TLIC_OFS_PRIO) begin
				source_priority_regs <= pwdata[NSRC-1:0]; // see (R3)
			end
		end
	end

	//----------------------------------------------------------------
	// Request evaluation
	//----------------------------------------------------------------
	always_comb begin
		if (priority_mode_enable) begin
			// see (R9) see (R10) see (R20)
			hi_pend = global_high_enable
				&& any_set(source_flag_regs & source_enable_regs & source_priority_regs);
			// see (R11) see (R13)
			lo_pend = global_high_enable && peripheral_low_enable && !svc_high
				&& any_set(source_flag_regs & source_enable_regs & ~source_priority_regs);
		end else begin
			// Priority selectors play no part here; see (R5) see (R6) see (R7)
			hi_pend = global_high_enable
				&& (any_set(source_flag_regs & source_enable_regs & ~PERIPH_MASK)
				|| (peripheral_low_enable
				&& any_set(source_flag_regs & source_enable_regs & PERIPH_MASK)));
			lo_pend = 1'b0;
		end
	end

	// High wins when both are pending; a low routine does not block it, see (R2)
	assign accept = st == TLIC_IDLE && instr_cycle && (hi_pend || lo_pend);
	assign entry = st == TLIC_WAIT && instr_cycle && icnt == `TLIC_ENTRY_ICYC - 2'h1;

	//----------------------------------------------------------------
	// Entry sequencer
	//----------------------------------------------------------------
	// Counting whole instruction cycles keeps latency independent of instruction length, see (R17)
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st <= TLIC_IDLE;
			icnt <= 2'h0;
			ent_high <= 1'b0;
		end else begin
			case (st)
				TLIC_IDLE: begin
					icnt <= 2'h0;
					if (accept) begin
						st <= TLIC_WAIT;
						ent_high <= hi_pend;
					end
				end
				TLIC_WAIT: begin
					if (entry) begin
						st <= TLIC_IDLE;
						icnt <= 2'h0;
					end else if (instr_cycle) begin
						icnt <= icnt + 2'h1;
					end
				end
				default: begin
					st <= TLIC_IDLE;
					icnt <= 2'h0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stack_push <= 1'b0;
			pc_load <= 1'b0;
			pc_vector <= `TLIC_VEC_HIGH;
		end else begin
			stack_push <= entry; // see (R14)
			pc_load <= entry; // see (R14)
			if (entry) begin
				pc_vector <= ent_high ? `TLIC_VEC_HIGH : `TLIC_VEC_LOW; // see (R1) see (R8)
			end
		end
	end

	//----------------------------------------------------------------
	// Global enables and service tracking
	//----------------------------------------------------------------
	// Hardware clear and set on entry or return win over a software write
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			global_high_enable <= 1'b0;
			peripheral_low_enable <= 1'b0;
			priority_mode_enable <= 1'b0; // see (R4)
		end else if (accept) begin
			if (hi_pend) begin
				global_high_enable <= 1'b0; // see (R12)
			end else begin
				peripheral_low_enable <= 1'b0; // see (R12)
			end
		end else if (return_from_interrupt_instr && st == TLIC_IDLE && (svc_high || svc_low)) begin
			if (svc_high) begin
				global_high_enable <= 1'b1; // see (R16)
			end else begin
				peripheral_low_enable <= 1'b1; // see (R16)
			end
		end else if (wr_acc && paddr == `TLIC_OFS_CTRL) begin
			global_high_enable <= pwdata[`TLIC_BIT_GHE];
			peripheral_low_enable <= pwdata[`TLIC_BIT_PLE];
			priority_mode_enable <= pwdata[`TLIC_BIT_PME];
		end
	end

	// A high routine nested in a low one returns first and leaves the low one marked
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			svc_high <= 1'b0;
			svc_low <= 1'b0;
		end else if (accept) begin
			if (hi_pend) begin
				svc_high <= 1'b1;
			end else begin
				svc_low <= 1'b1;
			end
		end else if (return_from_interrupt_instr && st == TLIC_IDLE) begin
			if (svc_high) begin
				svc_high <= 1'b0; // see (R16)
			end else begin
				svc_low <= 1'b0; // see (R16)
			end
		end
	end

	//----------------------------------------------------------------
	// Checks
	//----------------------------------------------------------------
	sequence s_entry_hi;
		accept && hi_pend ##1 ent_high;
	endsequence

	property p_vec_high;
		@(posedge sys_clk) disable iff (!nrst)
		pc_load && $past(ent_high) |-> pc_vector == `TLIC_VEC_HIGH;
	endproperty
	a_vec_high: assert property (p_vec_high) else $error("high entry not at 0008h"); // see (R1)

	property p_vec_low;
		@(posedge sys_clk) disable iff (!nrst)
		pc_load && !$past(ent_high) |-> pc_vector == `TLIC_VEC_LOW;
	endproperty
	a_vec_low: assert property (p_vec_low) else $error("low entry not at 0018h"); // see (R1)

	property p_compat_one_vec;
		@(posedge sys_clk) disable iff (!nrst)
		accept && !priority_mode_enable |=> ent_high;
	endproperty
	a_compat_one_vec: assert property (p_compat_one_vec) else $error("compat entry not high"); // see (R8)

	property p_clear_high;
		@(posedge sys_clk) disable iff (!nrst)
		s_entry_hi |-> !global_high_enable && svc_high;
	endproperty
	a_clear_high: assert property (p_clear_high) else $error("high enable kept on entry"); // see (R12)

	property p_clear_low;
		@(posedge sys_clk) disable iff (!nrst)
		accept && !hi_pend |=> !peripheral_low_enable && svc_low;
	endproperty
	a_clear_low: assert property (p_clear_low) else $error("low enable kept on entry"); // see (R12)

	property p_no_low_in_high;
		@(posedge sys_clk) disable iff (!nrst)
		svc_high |=> !$rose(svc_low);
	endproperty
	a_no_low_in_high: assert property (p_no_low_in_high) else $error("low taken in high routine"); // see (R13)

	property p_push_pairs;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(pc_load) |-> stack_push ##1 !pc_load;
	endproperty
	a_push_pairs: assert property (p_push_pairs) else $error("vector load without push"); // see (R14)

	property p_flag_set;
		@(posedge sys_clk) disable iff (!nrst)
		ev_rise[0] |=> source_flag_regs[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event lost"); // see (R18)

	property p_return_high;
		@(posedge sys_clk) disable iff (!nrst)
		return_from_interrupt_instr && st == TLIC_IDLE && svc_high && !accept
		|=> global_high_enable && !svc_high;
	endproperty
	a_return_high: assert property (p_return_high) else $error("return left high off"); // see (R16)

	property p_latency;
		@(posedge sys_clk) disable iff (!nrst)
		pc_load |-> $past(st) == TLIC_WAIT && $past(icnt) == `TLIC_ENTRY_ICYC - 2'h1;
	endproperty
	a_latency: assert property (p_latency) else $error("entry latency wrong"); // see (R17)

	property p_default_mode;
		@(posedge sys_clk) $rose(nrst) |-> !priority_mode_enable;
	endproperty
	a_default_mode: assert property (p_default_mode) else $error("priority mode on at reset"); // see (R4)

	// A low routine keeps its mark while a high one nests inside it
	sequence s_preempt;
		svc_low && hi_pend && st == TLIC_IDLE && instr_cycle;
	endsequence

	property p_preempt_low;
		@(posedge sys_clk) disable iff (!nrst)
		s_preempt |=> svc_high && svc_low;
	endproperty
	a_preempt_low: assert property (p_preempt_low) else $error("no preemption of low routine"); // see (R2)

	property p_return_low;
		@(posedge sys_clk) disable iff (!nrst)
		return_from_interrupt_instr && st == TLIC_IDLE && !svc_high && svc_low && !accept
		|=> peripheral_low_enable && !svc_low;
	endproperty
	a_return_low: assert property (p_return_low) else $error("return left low off"); // see (R16)

	property p_flag_hold;
		@(posedge sys_clk) disable iff (!nrst)
		source_flag_regs[0] && !flag_clr[0] |=> source_flag_regs[0];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear"); // see (R15)

	property p_enable_gates;
		@(posedge sys_clk) disable iff (!nrst)
		accept |-> any_set(source_flag_regs & source_enable_regs);
	endproperty
	a_enable_gates: assert property (p_enable_gates) else $error("entry without enabled flag"); // see (R3)

	property p_off_blocks;
		@(posedge sys_clk) disable iff (!nrst)
		accept |-> global_high_enable;
	endproperty
	a_off_blocks: assert property (p_off_blocks) else $error("entry with global enable clear"); // see (R7) see (R10)

	property p_low_both;
		@(posedge sys_clk) disable iff (!nrst)
		accept && priority_mode_enable && !hi_pend |-> global_high_enable && peripheral_low_enable;
	endproperty
	a_low_both: assert property (p_low_both) else $error("low entry without both enables"); // see (R11)

	property p_periph_gate;
		@(posedge sys_clk) disable iff (!nrst)
		accept && !priority_mode_enable && !any_set(source_flag_regs & source_enable_regs & ~PERIPH_MASK)
		|-> peripheral_low_enable;
	endproperty
	a_periph_gate: assert property (p_periph_gate) else $error("peripheral entry while gated"); // see (R6)
endmodule : tlic_ctrl
`default_nettype wire

// file: tb/tlic_core_model.sv
// Behavioural model of the core's instruction sequencer and return stack
`timescale 1ns/1ns
`default_nettype none
module tlic_core_model (
	input wire logic sys_clk, // Core clock
	input wire logic nrst, // Reset, active low
	input wire logic ret_req, // Bench asks for a return
	input wire logic stack_push, // Entry push
	input wire logic pc_load, // Entry vector load
	input wire logic [15:0] pc_vector, // Vector address
	output logic instr_cycle, // One pulse every four clocks
	output logic return_from_interrupt_instr, // Return executed
	output logic [15:0] pc, // Program counter
	output logic [3:0] depth // Return stack depth
);
	logic [1:0] phase;
	logic ret_pend;
	//----------------------------------------------------------------
	// Instruction timing
	//----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			phase <= 2'h0;
			instr_cycle <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			instr_cycle <= (phase == 2'h3);
		end
	end
	// A return only retires on an instruction boundary, as a real opcode would
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ret_pend <= 1'b0;
			return_from_interrupt_instr <= 1'b0;
		end else begin
			return_from_interrupt_instr <= 1'b0;
			if (ret_req) begin
				ret_pend <= 1'b1;
			end else if (ret_pend && phase == 2'h3) begin
				ret_pend <= 1'b0;
				return_from_interrupt_instr <= 1'b1;
			end
		end
	end
	//----------------------------------------------------------------
	// Stack and program counter
	//----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pc <= 16'h0000;
			depth <= 4'h0;
		end else if (stack_push && pc_load) begin
			depth <= depth + 4'h1;
			pc <= pc_vector;
		end else if (return_from_interrupt_instr && depth != 4'h0) begin
			depth <= depth - 4'h1;
		end
	end
endmodule : tlic_core_model
`default_nettype wire

// file: tb/two_level_interrupt_controller_tb_top.sv
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "tlic_params.svh"
module two_level_interrupt_controller_tb_top;
	logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, ret_req, e;
	logic instr_cycle, ret_ins, stack_push, pc_load, svc_high, svc_low;
	logic [7:0] paddr, src_event;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] pc_vector, pc;
	logic [3:0] depth;
	int err_total, n_tests, cyc0;
	int cyc = 0;
	tlic_ctrl uut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.src_event(src_event), .instr_cycle(instr_cycle), .return_from_interrupt_instr(ret_ins),
		.stack_push(stack_push), .pc_load(pc_load), .pc_vector(pc_vector), .svc_high(svc_high),
		.svc_low(svc_low));
	tlic_core_model core (.sys_clk(sys_clk), .nrst(nrst), .ret_req(ret_req), .stack_push(stack_push),
		.pc_load(pc_load), .pc_vector(pc_vector), .instr_cycle(instr_cycle),
		.return_from_interrupt_instr(ret_ins), .pc(pc), .depth(depth));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;
	//----------------------------------------------------------------
	// Access and check tasks
	//----------------------------------------------------------------
	task test_done;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			chk({31'h0, pready}, 32'h1);
			test_done;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask : rd
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	// Pulse held four clocks so the synchroniser cannot miss it
	task ev(input int i);
		@(posedge sys_clk);
		src_event[i] <= 1'b1;
		cyc0 = cyc;
		repeat (4) @(posedge sys_clk);
		src_event[i] <= 1'b0;
	endtask : ev
	task go(input logic [15:0] v, input logic exp, input logic lat);
		int k;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pc_load !== 1'b1 && k < 60);
		chk({31'h0, k < 60}, {31'h0, exp});
		if (exp && k >= 60) test_done;
		if (exp) begin
			chk({16'h0, pc_vector}, {16'h0, v});
			chk({31'h0, stack_push}, 32'h1);
			// Pin change to vector load: three to four instruction cycles of four clocks
			if (lat) chk({31'h0, cyc - cyc0 >= 12 && cyc - cyc0 <= 16}, 32'h1);
			@(posedge sys_clk);
			chk({16'h0, pc}, {16'h0, v});
		end
	endtask : go
	task ret;
		@(posedge sys_clk);
		ret_req <= 1'b1;
		@(posedge sys_clk);
		ret_req <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask : ret
	//----------------------------------------------------------------
	// Tests
	//----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, ret_req, nrst} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		src_event = 8'h00;
		err_total = 0;
		n_tests = 0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(`TLIC_OFS_CTRL, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("Test reset done");
		ev(0);
		go(16'h0, 1'b0, 1'b0);
		rd(`TLIC_OFS_FLAG, 32'h1);
		wr(`TLIC_OFS_FLAG, 32'h1);
		rd(`TLIC_OFS_FLAG, 32'h0);
		$display("Test flags done");
		wr(`TLIC_OFS_ENABLE, 32'h11);
		wr(`TLIC_OFS_PRIO, 32'h11);
		rd(`TLIC_OFS_ENABLE, 32'h11);
		rd(`TLIC_OFS_PRIO, 32'h11);
		// Control words change by single bus writes only, never by a two-step move
		wr(`TLIC_OFS_CTRL, 32'h80);
		ev(4);
		go(16'h0, 1'b0, 1'b0);
		ev(0);
		go(16'h0008, 1'b1, 1'b1);
		rd(`TLIC_OFS_CTRL, 32'h0);
		rd(`TLIC_OFS_STATUS, 32'h2);
		wr(`TLIC_OFS_FLAG, 32'h1);
		ret;
		rd(`TLIC_OFS_CTRL, 32'h80);
		wr(`TLIC_OFS_CTRL, 32'hc0);
		go(16'h0008, 1'b1, 1'b0);
		rd(`TLIC_OFS_CTRL, 32'h40);
		ret;
		go(16'h0008, 1'b1, 1'b0);
		wr(`TLIC_OFS_FLAG, 32'h10);
		ret;
		rd(`TLIC_OFS_CTRL, 32'hc0);
		chk({28'h0, depth}, 32'h0);
		$display("Test compatibility done");
		wr(`TLIC_OFS_ENABLE, 32'h06);
		wr(`TLIC_OFS_PRIO, 32'h04);
		wr(`TLIC_OFS_CTRL, 32'h60);
		ev(1);
		go(16'h0, 1'b0, 1'b0);
		wr(`TLIC_OFS_CTRL, 32'he0);
		go(16'h0018, 1'b1, 1'b0);
		rd(`TLIC_OFS_CTRL, 32'ha0);
		ev(2);
		go(16'h0008, 1'b1, 1'b1);
		chk({30'h0, svc_high, svc_low}, 32'h3);
		chk({28'h0, depth}, 32'h2);
		rd(`TLIC_OFS_CTRL, 32'h20);
		wr(`TLIC_OFS_FLAG, 32'h4);
		wr(`TLIC_OFS_CTRL, 32'he0);
		go(16'h0, 1'b0, 1'b0);
		wr(`TLIC_OFS_FLAG, 32'h2);
		// Both enables off so each return must restore its own one
		wr(`TLIC_OFS_CTRL, 32'h20);
		ret;
		chk({30'h0, svc_high, svc_low}, 32'h1);
		rd(`TLIC_OFS_CTRL, 32'ha0);
		ret;
		chk({30'h0, svc_high, svc_low}, 32'h0);
		rd(`TLIC_OFS_CTRL, 32'he0);
		chk({28'h0, depth}, 32'h0);
		$display("Test priority done");
		test_done;
	end
endmodule : two_level_interrupt_controller_tb_top
`default_nettype wire
